/* File: dahr_adc_model.sv */
// Behavioural model of the dual converter at the far end of the link.
`default_nettype none

module dahr_adc_model (
    input  wire logic        sclk,
    input  wire logic        select_n,
    input  wire logic [11:0] res_a,
    input  wire logic [11:0] res_b,
    output var  logic        line_a,
    output var  logic        line_b,
    output var  logic [5:0]  falls
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] sh_a;
    logic [31:0] sh_b;
    logic        powered_down;

    initial begin
        line_a = 1'b1;
        line_b = 1'b0;
        falls = 6'h00;
        powered_down = 1'b0;
    end
    always @(negedge select_n) begin
        sh_a = {2'b00, res_a, 4'h0, res_b, 2'b00};
        sh_b = {2'b00, res_b, 4'h0, res_a, 2'b00};
        falls = 6'h00;
        line_a = 1'b0;
        line_b = 1'b0;
    end
    always @(negedge sclk) if (!select_n && falls < 6'h20) begin
        falls = falls + 6'h01;
        sh_a = sh_a << 1;
        sh_b = sh_b << 1;
        if (falls == 6'h20) begin
            line_a = ~line_a;
            line_b = ~line_b;
        end else begin
            line_a = sh_a[31];
            line_b = sh_b[31];
        end
    end
    always @(posedge select_n) begin
        powered_down = falls >= 6'h02 && falls < 6'h0a;
        line_a = ~line_a;
        line_b = ~line_b;
    end
endmodule // dahr_adc_model

`default_nettype wire

/* File: dahr_pkg.sv */
// Constants, field layouts and types of the dual result line serial reader.
// Function
// - Active-low frame sync drives sample select
// - Fresh frame sync for every word
// - Normal word is 16 bits, 14 allowed
// - Eight-clock frame enters power-down mode
// - Latch result bits on falling clock edge
// - Assemble words most significant bit first
// - Words right justified, upper bits zero
// - Capture both result lines in one frame
// - One internally made clock serves both receivers
// - One frame sync output feeds both receivers
// - Frame starts spaced by whole clock periods
// - Optional free-running clock with burst frames
// - Conversion needs at least fourteen clocks
// - Early sync release aborts into power-down
`default_nettype none

package dahr_pkg;

    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_DIV      = 8'h04;
    localparam logic [7:0]  OFF_PERIOD   = 8'h08;
    localparam logic [7:0]  OFF_STATUS   = 8'h0c;
    localparam logic [7:0]  OFF_DATA_A   = 8'h10;
    localparam logic [7:0]  OFF_DATA_B   = 8'h14;

    localparam int          CTRL_RUN     = 0;
    localparam int          CTRL_SINGLE  = 1;
    localparam int          CTRL_WLEN_LO = 4;
    localparam int          CTRL_FREE    = 8;
    localparam int          STAT_BUSY    = 0;
    localparam int          STAT_DONE    = 1;

    localparam logic [1:0]  WLEN_16      = 2'h0;
    localparam logic [1:0]  WLEN_14      = 2'h1;
    localparam logic [1:0]  WLEN_8       = 2'h2;
    localparam logic [4:0]  WORD_16      = 5'h10;
    localparam logic [4:0]  WORD_14      = 5'h0e;
    localparam logic [4:0]  WORD_8       = 5'h08;

    localparam logic [15:0] DIV_RESET    = 16'h0004;
    localparam logic [15:0] DIV_MIN      = 16'h0003;
    localparam logic [15:0] PERIOD_RESET = 16'h0014;
    localparam logic [16:0] SPACE_FULL   = 17'h1ffff;

    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic       free_run;
        logic [1:0] wlen;
        logic       run;
    } dahr_ctrl_type;

    localparam dahr_ctrl_type CTRL_RESET = '{free_run: 1'b0, wlen: WLEN_16, run: 1'b0};

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_FRAME = 2'b10
    } dahr_state_type;

endpackage : dahr_pkg

`default_nettype wire

/* File: dahr_reader.sv */
// Host-side reader: AXI4-Lite registers, serial clock, frame sync and two receive lanes.
`default_nettype none

module dahr_reader
    import dahr_pkg::*;
#(
    parameter int LANES = 2,
    parameter int W     = 16
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output var  logic        receive_serial_clock,
    output var  logic        transmit_frame_sync,
    input  wire logic        result_line_a,
    input  wire logic        result_line_b
);

    dahr_ctrl_type  ctrl;
    dahr_state_type state;
    logic [15:0]    div_reg;
    logic [15:0]    period_reg;
    logic [15:0]    div_cnt;
    logic [15:0]    div_eff;
    logic [16:0]    space_cnt;
    logic [4:0]     edge_cnt;
    logic [4:0]     frame_words;
    logic [4:0]     next_words;
    logic [31:0]    data_a;
    logic [31:0]    data_b;
    logic           single_pend;
    logic           done;
    logic           tick;
    logic           go;
    logic           start_p;
    logic           fall_p;
    logic           end_p;
    logic [7:0]     aw_addr;
    logic [31:0]    w_data;
    logic [3:0]     w_strb;
    logic           do_wr;
    logic [7:0]     wr_off;
    logic [31:0]    rd_mux;
    logic [1:0]     rd_resp;
    logic [LANES-1:0]  lines;
    logic [W-1:0]      lane_word [LANES];

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // AXI4-Lite write path: address and data are taken in either order.
    assign wr_off = {aw_addr[7:2], 2'b00};
    assign do_wr  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                case (wr_off)
                    OFF_CTRL, OFF_DIV, OFF_PERIOD, OFF_STATUS: s_axi_bresp <= RESP_OKAY;
                    default:                                   s_axi_bresp <= RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Software-written configuration.
    always_ff @(posedge aclk) begin
        logic [31:0] v;
        v = 32'h0000_0000;
        if (!aresetn) begin
            ctrl       <= CTRL_RESET;
            div_reg    <= DIV_RESET;
            period_reg <= PERIOD_RESET;
        end else if (do_wr) begin
            case (wr_off)
                OFF_CTRL: begin
                    v = merge({23'h0, ctrl.free_run, 2'h0, ctrl.wlen, 3'h0, ctrl.run},
                              w_data, w_strb);
                    ctrl.run      <= v[CTRL_RUN];
                    ctrl.wlen     <= v[CTRL_WLEN_LO +: 2];
                    ctrl.free_run <= v[CTRL_FREE];
                end
                OFF_DIV: begin
                    v = merge({16'h0000, div_reg}, w_data, w_strb);
                    div_reg <= v[15:0];
                end
                OFF_PERIOD: begin
                    v = merge({16'h0000, period_reg}, w_data, w_strb);
                    period_reg <= v[15:0];
                end
                default: begin
                    v = 32'h0000_0000;
                end
            endcase
        end
    end

    // A single-shot request waits until its frame starts; a new request wins over the clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            single_pend <= 1'b0;
        end else if (do_wr && wr_off == OFF_CTRL && w_strb[0] && w_data[CTRL_SINGLE]) begin
            single_pend <= 1'b1;
        end else if (start_p) begin
            single_pend <= 1'b0;
        end
    end

    // Done is sticky, cleared by writing one; a frame end in the same cycle wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done <= 1'b0;
        end else if (end_p) begin
            done <= 1'b1;
        end else if (do_wr && wr_off == OFF_STATUS && w_strb[0] && w_data[STAT_DONE]) begin
            done <= 1'b0;
        end
    end

    // AXI4-Lite read path with a registered answer one cycle after the address.
    always_comb begin
        rd_mux  = 32'h0000_0000;
        rd_resp = RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
            OFF_CTRL: begin
                rd_mux[CTRL_RUN]           = ctrl.run;
                rd_mux[CTRL_SINGLE]        = single_pend;
                rd_mux[CTRL_WLEN_LO +: 2]  = ctrl.wlen;
                rd_mux[CTRL_FREE]          = ctrl.free_run;
            end
            OFF_DIV:    rd_mux = {16'h0000, div_reg};
            OFF_PERIOD: rd_mux = {16'h0000, period_reg};
            OFF_STATUS: begin
                rd_mux[STAT_BUSY] = (state == ST_FRAME);
                rd_mux[STAT_DONE] = done;
            end
            OFF_DATA_A: rd_mux = data_a;
            OFF_DATA_B: rd_mux = data_b;
            default:    rd_resp = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_resp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Half-period divider of the serial clock made here from aclk.
    assign div_eff = (div_reg < DIV_MIN) ? DIV_MIN : div_reg;
    assign tick    = (div_cnt >= div_eff - 16'h0001);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 16'h0000;
        end else if (tick) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end

    always_comb begin
        case (ctrl.wlen)
            WLEN_14: next_words = WORD_14;
            WLEN_8:  next_words = WORD_8;
            default: next_words = WORD_16;
        endcase
    end

    // Frame starts are spaced by at least twice the period value in half periods, exactly that count when the frame ends sooner.
    assign go      = (ctrl.run || single_pend) && (space_cnt >= {period_reg, 1'b0});
    assign start_p = tick && (state == ST_IDLE) && go
                     && (!receive_serial_clock || !ctrl.free_run);
    assign fall_p  = tick && (state == ST_FRAME) && receive_serial_clock;
    assign end_p   = tick && (state == ST_FRAME) && !receive_serial_clock
                     && (edge_cnt == frame_words);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            space_cnt <= SPACE_FULL;
        end else if (start_p) begin
            space_cnt <= 17'h00001;
        end else if (tick && space_cnt != SPACE_FULL) begin
            space_cnt <= space_cnt + 17'h00001;
        end
    end

    // Frame engine: sync falls with the clock high, then one falling edge per bit.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state                <= ST_IDLE;
            receive_serial_clock <= 1'b1;
            transmit_frame_sync  <= 1'b1;
            edge_cnt             <= 5'h00;
            frame_words          <= WORD_16;
        end else if (tick) begin
            case (state)
                ST_IDLE: begin
                    if (start_p) begin
                        state                <= ST_FRAME;
                        transmit_frame_sync  <= 1'b0;
                        receive_serial_clock <= 1'b1;
                        edge_cnt             <= 5'h00;
                        frame_words          <= next_words;
                    end else if (ctrl.free_run) begin
                        receive_serial_clock <= !receive_serial_clock;
                    end else begin
                        receive_serial_clock <= 1'b1;
                    end
                end
                ST_FRAME: begin
                    if (end_p) begin
                        state                <= ST_IDLE;
                        transmit_frame_sync  <= 1'b1;
                        receive_serial_clock <= 1'b1;
                    end else begin
                        receive_serial_clock <= !receive_serial_clock;
                        if (receive_serial_clock) begin
                            edge_cnt <= edge_cnt + 5'h01;
                        end
                    end
                end
                default: begin
                    state                <= ST_IDLE;
                    transmit_frame_sync  <= 1'b1;
                    receive_serial_clock <= 1'b1;
                end
            endcase
        end
    end

    // Both result lines are shifted on the same clock and frame.
    assign lines = {result_line_b, result_line_a};

    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            dahr_rx_lane #(
                .W (W)
            ) u_lane (
                .aclk    (aclk),
                .aresetn (aresetn),
                .line    (lines[g]),
                .clear   (start_p),
                .shift   (fall_p),
                .word    (lane_word[g])
            );
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_a <= 32'h0000_0000;
            data_b <= 32'h0000_0000;
        end else if (end_p) begin
            data_a <= {{(32 - W){1'b0}}, lane_word[0]};
            data_b <= {{(32 - W){1'b0}}, lane_word[LANES-1]};
        end
    end

endmodule // dahr_reader

`default_nettype wire

/* File: dahr_reader_chk_asserts.sv */
// Concurrent checks on the link pins and register bus of the reader.
`default_nettype none

module dahr_reader_chk
    import dahr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic receive_serial_clock,
    input wire logic transmit_frame_sync
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_reset_idle;
        disable iff (1'b0) !aresetn |=> transmit_frame_sync && receive_serial_clock;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("link not idle after reset");
    property p_start_high;
        $fell(transmit_frame_sync) |-> receive_serial_clock;
    endproperty
    a_start_high: assert property (p_start_high)
        else $error("frame began with clock low");
    property p_end_high;
        $rose(transmit_frame_sync) |-> receive_serial_clock;
    endproperty
    a_end_high: assert property (p_end_high)
        else $error("frame ended with clock low");
    property p_half_period;
        $changed(receive_serial_clock) && !transmit_frame_sync
            |=> $stable(receive_serial_clock)[*2];
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("serial clock half period too short");
    property p_frame_len;
        $fell(transmit_frame_sync) |-> (!transmit_frame_sync)[*8];
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame sync released too soon");
    property p_gap;
        $rose(transmit_frame_sync) |-> transmit_frame_sync[*3];
    endproperty
    a_gap: assert property (p_gap)
        else $error("no gap between frames");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold)
        else $error("write response dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold)
        else $error("read data dropped");
    property p_ranswer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_ranswer: assert property (p_ranswer)
        else $error("read answer late");
    property p_wanswer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wanswer: assert property (p_wanswer)
        else $error("write answer late");
endmodule // dahr_reader_chk

bind dahr_reader dahr_reader_chk dahr_reader_chk_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .receive_serial_clock(receive_serial_clock), .transmit_frame_sync(transmit_frame_sync));

`default_nettype wire

/* File: dahr_rx_lane.sv */
// One receive lane: pin synchroniser and most-significant-first shift register.
`default_nettype none

module dahr_rx_lane
    import dahr_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         line,
    input  wire logic         clear,
    input  wire logic         shift,
    output var  logic [W-1:0] word
);

    logic sync_1;
    logic sync_2;

    // Two flip-flops before any logic reads the pin.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_1 <= 1'b0;
            sync_2 <= 1'b0;
        end else begin
            sync_1 <= line;
            sync_2 <= sync_1;
        end
    end

    // Clearing at frame start leaves short words right justified with zero fill.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word <= '0;
        end else if (clear) begin
            word <= '0;
        end else if (shift) begin
            word <= {word[W-2:0], sync_2};
        end
    end

endmodule // dahr_rx_lane

`default_nettype wire

/* File: dahr_tb.sv */
// Self-checking bench of the dual result line reader.
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module testbench import dahr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, sclk, sync_n, line_a, line_b;
    logic [11:0] ra, rb;
    logic [5:0]  falls;
    logic [34:0] q[$];
    logic [34:0] e;
    int          num_errors = 0, n_checks = 0, seed = 21766, cyc = 0, last = 0;
    int          spacing = 0, n;

    always #4 aclk = ~aclk;

    dahr_reader dahr_reader_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .receive_serial_clock(sclk), .transmit_frame_sync(sync_n),
        .result_line_a(line_a), .result_line_b(line_b));
    dahr_adc_model dahr_adc_model_inst (.sclk(sclk), .select_n(sync_n), .res_a(ra),
        .res_b(rb), .line_a(line_a), .line_b(line_b), .falls(falls));

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        q.push_back({1'b0, r, 32'h0});
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'($random(seed));
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        q.push_back({1'b1, r, d});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'($random(seed));
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && !rready) rready <= 1'b1;
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask

    task automatic finish_test();
        if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge aclk) if (aresetn) begin
        if (bvalid && bready) begin
            e = q.pop_front();
            `CHK("bresp", e[33:32], bresp)
        end
        if (rvalid && rready) begin
            e = q.pop_front();
            `CHK("rresp", e[33:32], rresp)
            `CHK("rdata", e[31:0], rdata)
        end
    end

    always @(posedge aclk) begin
        cyc++;
        if ($fell(sync_n)) begin
            spacing <= cyc - last;
            last <= cyc;
        end
        if (cyc == 40000) begin
            num_errors++;
            finish_test();
        end
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, ra, rb} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_CTRL, 32'h0, RESP_OKAY);
        rd(OFF_DIV, {16'h0, DIV_RESET}, RESP_OKAY);
        rd(OFF_PERIOD, {16'h0, PERIOD_RESET}, RESP_OKAY);
        rd(OFF_STATUS, 32'h0, RESP_OKAY);
        rd(OFF_DATA_A, 32'h0, RESP_OKAY);
        rd(8'h20, 32'h0, RESP_SLVERR);
        wr(OFF_DATA_B, 32'h1, 4'hf, RESP_SLVERR);
        wr(8'h1c, 32'h1, 4'hf, RESP_SLVERR);
        wr(OFF_DIV, 32'h0000ff05, 4'h1, RESP_OKAY);
        rd(OFF_DIV, 32'h5, RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            ra = 12'($random(seed));
            rb = 12'($random(seed));
            n = (i % 4 == 1) ? 14 : (i % 4 == 2) ? 8 : 16;
            wr(OFF_DIV, 32'(3 + ($random(seed) & 3)), 4'hf, RESP_OKAY);
            wr(OFF_CTRL, (32'(i == 4) << CTRL_FREE) | (32'(i % 4) << CTRL_WLEN_LO) | 32'h2,
               4'hf, RESP_OKAY);
            wait (!sync_n);
            rd(OFF_STATUS, 32'h1, RESP_OKAY);
            wait (sync_n);
            `CHK("falls", 6'(n), falls)
            rd(OFF_DATA_A, 32'({2'b00, ra, 2'b00} >> (16 - n)), RESP_OKAY);
            `CHK("pdown", 1'(n == 8), dahr_adc_model_inst.powered_down)
            rd(OFF_DATA_B, 32'({2'b00, rb, 2'b00} >> (16 - n)), RESP_OKAY);
            rd(OFF_STATUS, 32'h2, RESP_OKAY);
            wr(OFF_STATUS, 32'h2, 4'hf, RESP_OKAY);
            rd(OFF_STATUS, 32'h0, RESP_OKAY);
        end
        wr(OFF_CTRL, 32'h0, 4'hf, RESP_OKAY);
        wr(OFF_DIV, 32'h4, 4'hf, RESP_OKAY);
        wr(OFF_PERIOD, 32'd24, 4'hf, RESP_OKAY);
        wr(OFF_CTRL, 32'h1, 4'hf, RESP_OKAY);
        repeat (3) @(negedge sync_n);
        repeat (2) @(posedge aclk);
        `CHK("spacing", 192, spacing)
        wr(OFF_CTRL, 32'h0, 4'hf, RESP_OKAY);
        wait (sync_n);
        rd(OFF_DATA_B, 32'({2'b00, rb, 2'b00}), RESP_OKAY);
        finish_test();
    end
endmodule // testbench

`default_nettype wire
